/* File: rtl/asp_map.svh */
// Purpose: timing constants for the byte-wide static memory host port
// Assumes: ref_clk at 50 MHz, period 20 ns
// Notes:   counts derived from printed times, least times round up
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
`define ASP_CLK_PERIOD_NS      20
`define ASP_WRITE_PULSE_MIN_NS 35
`define ASP_DATA_SETUP_NS      25
`define ASP_ADDR_TO_VALID_NS   45
`define ASP_DRIVE_TO_VALID_NS  22
`define ASP_PERIOD_MIN_NS      45
`define ASP_TURNAROUND_NS      18
`define ASP_CYC(ns) (((ns) + `ASP_CLK_PERIOD_NS - 1) / `ASP_CLK_PERIOD_NS)
`define ASP_WR_CYC  `ASP_CYC(`ASP_WRITE_PULSE_MIN_NS)
`define ASP_RD_CYC  (`ASP_CYC(`ASP_ADDR_TO_VALID_NS) + 1)
`define ASP_TA_CYC  `ASP_CYC(`ASP_TURNAROUND_NS)
`define ASP_CNT_W   3
`define ASP_ADDR_W  17
`define ASP_DATA_W  8
`endif

/* File: rtl/asp_pkg.sv */
// Purpose: types for the static memory host port
// Assumes: nothing
// Notes:   constants live in asp_map.svh
package asp_pkg;
  typedef enum logic [2:0] {
    ASP_IDLE  = 3'b000,
    ASP_WRITE = 3'b001,
    ASP_WEND  = 3'b010,
    ASP_READ  = 3'b011,
    ASP_TURN  = 3'b100
  } asp_state_t;
endpackage

/* File: rtl/asp_sram_host.sv */
// Purpose: host controller driving a 128K x 8 asynchronous static memory
// Assumes: one request at a time, memory answers within printed delays
// Notes:   data pins split into in, out and active-low output enable
`timescale 1ns/1ns
`default_nettype none
`include "asp_map.svh"
module asp_sram_host
  import asp_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  input  wire logic                     reqValid,
  output logic                          reqReady,
  input  wire logic                     reqWrite,
  input  wire logic [`ASP_ADDR_W-1:0]   reqAddr,
  input  wire logic [`ASP_DATA_W-1:0]   reqWdata,
  output logic                          rdValid,
  output logic [`ASP_DATA_W-1:0]        rdData,
  input  wire logic                     retainReq,
  output logic                          retainOk,
  output logic [`ASP_ADDR_W-1:0]        memAddr,
  output logic                          select_low_active_n,
  output logic                          select_high_active,
  output logic                          memWe_n,
  output logic                          memOe_n,
  input  wire logic [`ASP_DATA_W-1:0]   memDataIn,
  output logic [`ASP_DATA_W-1:0]        memDataOut,
  output logic                          memDataOe_n
);
  // ******************************************
  // state and counters
  // ******************************************
  asp_state_t                   state_q, state_d;
  logic [`ASP_CNT_W-1:0]        cnt_q, cnt_d;
  logic [`ASP_ADDR_W-1:0]       addr_q;
  logic [`ASP_DATA_W-1:0]       wdata_q;
  logic [`ASP_DATA_W-1:0]       rdData_q;
  logic                         rdValid_q;
  logic                         sel_q, we_q, oe_q, drv_q;

  // a state is left on the edge after the count reaches zero, so a
  // phase of N cycles loads N-1; loading N would stretch every phase
  localparam logic [`ASP_CNT_W-1:0] WR_CNT = `ASP_CNT_W'(`ASP_WR_CYC - 1);
  localparam logic [`ASP_CNT_W-1:0] RD_CNT = `ASP_CNT_W'(`ASP_RD_CYC - 1);
  localparam logic [`ASP_CNT_W-1:0] TA_CNT = `ASP_CNT_W'(`ASP_TA_CYC - 1);

  wire cntDone  = (cnt_q == '0);
  wire idleFree = (state_q == ASP_IDLE);
  wire accept   = idleFree && reqValid && !retainReq;

  // ******************************************
  // sequencing
  // ******************************************
  // address and data are latched on the same edge that asserts select and strobe
  // and stay fixed the whole access, so hold past the end is met but there is no set-up before start
  always_comb begin
    state_d = state_q;
    cnt_d   = cntDone ? cnt_q : cnt_q - `ASP_CNT_W'(1);
    case (state_q)
      ASP_IDLE: begin
        if (accept) begin
          state_d = reqWrite ? ASP_WRITE : ASP_READ;
          cnt_d   = reqWrite ? WR_CNT : RD_CNT;
        end
      end
      ASP_WRITE: begin
        // strobe low 2 cycles (40 ns) covers pulse and data set-up
        if (cntDone) begin
          state_d = ASP_WEND;
        end
      end
      ASP_WEND: begin
        // one idle cycle holds data past the strobe edge, period 80 ns with the IDLE cycle
        state_d = ASP_IDLE;
      end
      ASP_READ: begin
        if (cntDone) begin
          state_d = ASP_TURN;
          cnt_d   = TA_CNT;
        end
      end
      ASP_TURN: begin
        // memory output may linger after deselect; wait before driving
        if (cntDone) begin
          state_d = ASP_IDLE;
        end
      end
      default: state_d = ASP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ASP_IDLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (accept) begin
      addr_q  <= reqAddr;
      wdata_q <= reqWdata;
    end
  end

  // ******************************************
  // pin drive
  // ******************************************
  wire selNext = (state_d == ASP_WRITE) || (state_d == ASP_READ);
  wire weNext  = (state_d == ASP_WRITE);
  wire oeNext  = (state_d == ASP_READ);
  // host drives data only during write phases, never while reading
  wire drvNext = (state_d == ASP_WRITE) || (state_d == ASP_WEND);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q <= 1'b0;
      we_q  <= 1'b0;
      oe_q  <= 1'b0;
      drv_q <= 1'b0;
    end else begin
      sel_q <= selNext;
      we_q  <= weNext;
      oe_q  <= oeNext;
      drv_q <= drvNext;
    end
  end

  // select and strobe fall together so memory never drives before write
  assign select_low_active_n = !sel_q;
  assign select_high_active  = sel_q;
  assign memWe_n             = !we_q;
  assign memOe_n             = !oe_q;
  assign memAddr             = addr_q;
  assign memDataOut          = wdata_q;
  assign memDataOe_n         = !drv_q;

  // ******************************************
  // read capture
  // ******************************************
  // memory data is held steady by then; no synchroniser needed
  wire rdCapture = (state_q == ASP_READ) && cntDone;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_q  <= '0;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= rdCapture;
      if (rdCapture) begin
        rdData_q <= memDataIn;
      end
    end
  end

  assign rdData   = rdData_q;
  assign rdValid  = rdValid_q;
  assign reqReady = idleFree && !retainReq;
  assign retainOk = idleFree && !sel_q;

  // ******************************************
  // checks
  // ******************************************
  AST_WE_INSIDE_SEL: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !memWe_n |-> !select_low_active_n && select_high_active)
    else $error("write strobe outside select");
  AST_SEL_PAIR: assert property (@(posedge ref_clk) disable iff (!reset_n)
    select_high_active == !select_low_active_n)
    else $error("select pins disagree");
  AST_WE_PULSE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(memWe_n) |-> !memWe_n [*2] ##1 memWe_n)
    else $error("write pulse not two cycles");
  AST_DATA_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(memWe_n) |-> !memDataOe_n && $stable(memDataOut))
    else $error("write data not held past strobe");
  AST_ADDR_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !select_low_active_n && !$past(select_low_active_n)
      |-> $stable(memAddr))
    else $error("address moved during access");
  AST_NO_CLASH: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !memOe_n |-> memDataOe_n)
    else $error("host drives while memory output on");
  AST_READ_LEN: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(memOe_n) |-> !memOe_n [*4] ##1 rdValid)
    else $error("read data taken too early");
  AST_RETAIN: assert property (@(posedge ref_clk) disable iff (!reset_n)
    retainOk && retainReq |=> select_low_active_n && retainOk)
    else $error("retention while selected");
endmodule // asp_sram_host
`default_nettype wire

/* File: verif/asp_sram_model.sv */
// Purpose: behavioural byte-wide static memory at the host's far side
// Assumes: host keeps write data driven through the write end
// Notes:   DLY sets the answer speed, 10 to 22 ns
`timescale 1ns/1ns
`default_nettype none
module asp_sram_model #(parameter int DLY = 10) (
  input  wire logic [16:0] memAddr,
  input  wire logic        selN,
  input  wire logic        selH,
  input  wire logic        weN,
  input  wire logic        oeN,
  input  wire logic [7:0]  dIn,
  output logic      [7:0]  dOut,
  output logic             drv
);
  // ****************
  // storage and pins
  // ****************
  logic [7:0] mem [bit [16:0]];
  wire        sel = !selN && selH;
  wire        wr  = sel && !weN;
  assign drv = sel && !oeN && weN;
  initial dOut = 8'h5a;
  // the power-up settle of the strobe pins must not store to an x address
  always @(negedge wr)
    if (!$isunknown(memAddr)) mem[memAddr] = dIn;
  // a released pin shows the inverse so a stale capture cannot pass
  always @(drv, memAddr)
    if (drv) dOut <= #DLY (mem.exists(memAddr) ? mem[memAddr] : 8'h00);
    else dOut <= #1 ~dOut;
endmodule // asp_sram_model
`default_nettype wire

/* File: verif/asp_sram_host_tb.sv */
// Purpose: self-checking bench for the static memory host port
// Assumes: memory model answers within 10 ns
// Notes:   reads are compared in the order they were issued
`timescale 1ns/1ns
`default_nettype none
`include "asp_map.svh"
module asp_sram_host_tb;
  logic [`ASP_ADDR_W-1:0] reqAddr, memAddr, a;
  logic [`ASP_DATA_W-1:0] reqWdata, rdData, memDataIn, memDataOut, bus;
  logic ref_clk, reset_n, reqValid, reqWrite, retainReq, reqReady;
  logic rdValid, retainOk, selN, selH, weN, oeN, dataOeN, drv;
  logic [7:0] expQ [$];
  logic [7:0] shadow [bit [16:0]];
  logic [16:0] aq [$];
  int mismatches = 0, tests_run = 0, seed = 37;
  assign bus = !dataOeN ? memDataOut : ~memDataOut;
  asp_sram_host i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .rdValid(rdValid),
    .rdData(rdData), .retainReq(retainReq), .retainOk(retainOk),
    .memAddr(memAddr), .select_low_active_n(selN),
    .select_high_active(selH), .memWe_n(weN), .memOe_n(oeN),
    .memDataIn(memDataIn), .memDataOut(memDataOut), .memDataOe_n(dataOeN));
  asp_sram_model i_mem (.memAddr(memAddr), .selN(selN), .selH(selH),
    .weN(weN), .oeN(oeN), .dIn(bus), .dOut(memDataIn), .drv(drv));
  // ********************
  // clock, checks, tasks
  // ********************
  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic check(string nm, logic [7:0] e, logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic req(input logic w, input logic [16:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    reqValid = 1;
    reqWrite = w;
    reqAddr = ad;
    reqWdata = d;
    while (reqReady !== 1'b1) begin
      n++;
      if (n > 20) begin
        mismatches++;
        conclude;
      end
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
    if (!w) expQ.push_back(shadow[ad]);
    @(negedge ref_clk);
    reqValid = 0;
  endtask
  always @(negedge ref_clk) begin
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) check("spare rdValid", 8'h00, 8'h01);
      else check("rdData", expQ.pop_front(), rdData);
    end
    if (!dataOeN && drv) check("bus clash", 8'h00, 8'h01);
  end
  // ***********
  // main script
  // ***********
  initial begin
    reset_n = 0;
    reqValid = 0;
    reqWrite = 0;
    reqAddr = '0;
    reqWdata = '0;
    retainReq = 0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk) reset_n = 1;
    check("select at reset", 8'h02, {6'h00, selN, selH});
    check("float at reset", 8'h01, {7'h00, dataOeN});
    for (int i = 0; i < 10; i++) begin
      a = (i == 0) ? 17'h00000 : (i < 3) ? 17'h1ffff : 17'($random(seed));
      shadow[a] = 8'($random(seed));
      aq.push_front(a);
      req(1'b1, a, shadow[a]);
    end
    foreach (aq[i]) req(1'b0, aq[i], 8'h00);
    @(negedge ref_clk) retainReq = 1;
    @(negedge ref_clk);
    check("ready in retain", 8'h00, {7'h00, reqReady});
    // the last read is still in flight; wait for it to drain
    for (int k = 0; k < 20 && retainOk !== 1'b1; k++) @(negedge ref_clk);
    if (retainOk !== 1'b1) begin
      mismatches++;
      conclude;
    end
    check("retainOk", 8'h01, {7'h00, retainOk});
    check("select in retain", 8'h02, {6'h00, selN, selH});
    retainReq = 0;
    req(1'b0, aq[0], 8'h00);
    repeat (8) @(negedge ref_clk);
    check("reads left", 8'h00, 8'(expQ.size()));
    conclude;
  end
endmodule // asp_sram_host_tb
`default_nettype wire
